// [src/serial_glue_pkg.sv]
package serial_glue_pkg;

  // =====================================================
  // divider and chain constants
  // =====================================================
  localparam int unsigned TIMER_DIV       = 2;   // system clock to timer input
  localparam int unsigned NET_DIV         = 5;   // system clock to network bit clock
  localparam int unsigned KBD_DIV         = 20;  // 1.5 mhz tick to keyboard clock
  localparam int unsigned IRQ_SOURCES     = 8;   // interrupt sources along the chain
  localparam int unsigned FIFO_DEPTH      = 16;  // words held in the data path
  localparam int unsigned FIFO_WIDTH      = 8;   // bits per buffered word
  localparam logic [7:0]  VECTOR_RESET    = 8'h00;
  localparam logic [7:0]  BITCOUNT_RESET  = 8'h00;

  // interrupt source bundle: requests and per-source vectors
  typedef struct packed {
    logic [IRQ_SOURCES-1:0]      req;     // bit 0 highest priority
    logic [IRQ_SOURCES-1:0][7:0] vector;  // vector per source
  } irq_bundle_s;

  // port a clock and nrzi coder selection
  typedef struct packed {
    logic clock_source_select_n;  // low selects on-board clocks
    logic nrzi_select_n;          // low routes data through coder
  } port_cfg_s;

endpackage : serial_glue_pkg

// [src/sync_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// flop-based fifo with valid/ready on both sides
// =====================================================
module sync_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire  logic             clock,
  input  wire  logic             rst_n,
  // fill side
  input  wire  logic             in_valid,
  output logic                   in_ready,
  input  wire  logic [WIDTH-1:0] in_data,
  // drain side
  output logic                   out_valid,
  input  wire  logic             out_ready,
  output logic [WIDTH-1:0]       out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];  // storage
  logic [AW-1:0]    wr_r;           // write index
  logic [AW-1:0]    rd_r;           // read index
  logic [AW:0]      cnt_r;          // occupancy
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_r[rd_r];

  // storage write, no reset needed for data
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop)  rd_r <= rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sync_fifo
`default_nettype wire

// [src/clock_divider.sv]
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// divide-by-n tick generator with square output
// =====================================================
module clock_divider #(
  parameter int unsigned DIV = 2
) (
  // clock and reset
  input  wire  logic clock,
  input  wire  logic rst_n,
  // input tick (tie high to divide the clock)
  input  wire  logic tick_in,
  // outputs
  output logic       tick_out,   // one-cycle pulse each DIV ticks
  output logic       level_out   // high for first DIV/2 counts of period, rounded down
);
  localparam int unsigned CW = $clog2(DIV+1);
  logic [CW-1:0] cnt_r;

  // counter wraps at DIV-1
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (tick_in) begin
      cnt_r <= (cnt_r == CW'(DIV-1)) ? '0 : cnt_r + 1'b1;
    end
  end

  assign tick_out  = tick_in & (cnt_r == CW'(DIV-1));
  assign level_out = (cnt_r < CW'(DIV/2));
endmodule : clock_divider
`default_nettype wire

// [src/serial_glue.sv]
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// clock routing and interrupt chain glue of serial board
// =====================================================
module serial_glue (
  // clock and reset
  input  wire  logic                          clock,
  input  wire  logic                          rst_n,
  // cpu board controls
  input  wire  logic                          clock_source_select_n,
  input  wire  logic                          nrzi_select_n,
  input  wire  logic                          kbd_ref_tick,      // 1.5 mhz enable pulse
  input  wire  logic                          reset_switch_sense,
  input  wire  logic                          vsync_strobe_n,
  input  wire  logic                          timer3_from_tx_clock, // high picks tx clock
  // cpu interrupt acknowledge
  input  wire  logic                          opcode_fetch_strobe_n,
  input  wire  logic                          io_request_strobe_n,
  output logic                                irq_n,
  output logic                                chain_enable_out,
  output logic [7:0]                          vector_data,
  output logic                                vector_drive,
  // controller interrupt sources
  input  wire  serial_glue_pkg::irq_bundle_s  irq_src,
  input  wire  logic [serial_glue_pkg::IRQ_SOURCES-1:0] in_service,
  // timer outputs (pulses)
  input  wire  logic [2:0]                    timer_out,
  output logic                                timer_clock_tick,  // channels 0-2
  output logic                                timer3_clock_tick,
  output logic [7:0]                          bit_count,
  // port a clocks and data
  input  wire  logic                          ext_receive_clock,
  input  wire  logic                          ext_transmit_clock,
  output logic                                porta_receive_clock,
  output logic                                porta_transmit_clock,
  input  wire  logic                          porta_txd,
  output logic                                line_txd,
  input  wire  logic                          line_rxd,
  output logic                                porta_rxd,
  // uart port a clock
  output logic                                uart_a_clock,
  // network port
  output logic                                network_link_clock,
  output logic                                network_carrier_detect_n,
  // keyboard port
  output logic                                keyboard_shared_serial_clock,
  output logic                                keyboard_ring_indicator_n,
  input  wire  logic                          keyboard_dtr_n,
  output logic                                keyboard_ready_n,
  // received data stream into buffer
  output logic                                rx_word_valid,
  input  wire  logic                          rx_word_ready,
  output logic [7:0]                          rx_word,
  output logic                                rx_overrun
);

  // =====================================================
  // declarations
  // =====================================================
  typedef enum logic [1:0] {
    ACK_IDLE  = 2'b00,  // no acknowledge running
    ACK_FETCH = 2'b01,  // fetch strobe seen
    ACK_DRIVE = 2'b10   // vector on the bus
  } ack_e;

  ack_e                       ack_r;
  ack_e                       ack_nxt;
  logic [serial_glue_pkg::IRQ_SOURCES:0] chain_en;   // enable into each source
  logic [2:0]                 winner_idx;            // highest requesting source
  logic                       any_req;
  logic [7:0]                 vector_r;
  logic                       vector_drive_r;
  logic [7:0]                 bit_count_r;
  logic                       tx_clock_prev_r;       // edge detect of timer 3 source
  logic                       nrzi_txc_prev_r;       // edge detect of port a tx clock
  logic                       timer3_src;
  logic                       tx_level_r;            // nrzi line level out
  logic                       rx_prev_r;             // previous received line level
  logic                       rx_decoded_r;
  logic                       rx_clock_prev_r;
  logic [7:0]                 shift_r;
  logic [2:0]                 shift_cnt_r;
  logic                       shift_push_r;
  logic                       fifo_in_ready;
  logic                       net_lvl;
  logic                       kbd_lvl;
  logic                       net_tick;

  // =====================================================
  // dividers
  // =====================================================
  // timer channels 0-2 run from system clock / 2
  clock_divider #(.DIV(serial_glue_pkg::TIMER_DIV)) u_timer_div (
    .clock     (clock),
    .rst_n     (rst_n),
    .tick_in   (1'b1),
    .tick_out  (timer_clock_tick),
    .level_out ()
  );

  // network bit clock: system clock / 5, one clock for both directions
  clock_divider #(.DIV(serial_glue_pkg::NET_DIV)) u_net_div (
    .clock     (clock),
    .rst_n     (rst_n),
    .tick_in   (1'b1),
    .tick_out  (net_tick),
    .level_out (net_lvl)
  );

  // keyboard clock: 1.5 mhz reference / 20
  clock_divider #(.DIV(serial_glue_pkg::KBD_DIV)) u_kbd_div (
    .clock     (clock),
    .rst_n     (rst_n),
    .tick_in   (kbd_ref_tick),
    .tick_out  (),
    .level_out (kbd_lvl)
  );

  // network clock level driven from a flop to avoid glitches
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      network_link_clock           <= 1'b0;
      keyboard_shared_serial_clock <= 1'b0;
    end else begin
      network_link_clock           <= net_lvl;
      keyboard_shared_serial_clock <= kbd_lvl;
    end
  end

  // =====================================================
  // sideband signals
  // =====================================================
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      network_carrier_detect_n  <= 1'b1;
      keyboard_ring_indicator_n <= 1'b1;
      keyboard_ready_n          <= 1'b1;
    end else begin
      network_carrier_detect_n  <= ~reset_switch_sense;
      keyboard_ring_indicator_n <= vsync_strobe_n;
      keyboard_ready_n          <= keyboard_dtr_n;
    end
  end

  // =====================================================
  // clock routing
  // =====================================================
  // selects come from the cpu latch and are steady between writes
  always_comb begin
    // on-board: timer 0 drives tx, timer 1 drives rx; else off-board
    if (!clock_source_select_n) begin
      porta_transmit_clock = timer_out[0];
      porta_receive_clock  = timer_out[1];
    end else begin
      porta_transmit_clock = ext_transmit_clock;
      porta_receive_clock  = ext_receive_clock;
    end
  end

  assign uart_a_clock = timer_out[2];

  // timer 3 input source
  assign timer3_src = timer3_from_tx_clock ? porta_transmit_clock : timer_out[0];

  // =====================================================
  // timer 3 bit counter
  // =====================================================
  // counts rising edges of its source; output pin stays unused
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_clock_prev_r <= 1'b0;
      bit_count_r     <= serial_glue_pkg::BITCOUNT_RESET;
    end else begin
      tx_clock_prev_r <= timer3_src;
      if (timer3_src && !tx_clock_prev_r) begin
        bit_count_r <= bit_count_r + 8'h01;
      end
    end
  end
  assign timer3_clock_tick = timer3_src & ~tx_clock_prev_r;
  assign bit_count         = bit_count_r;

  // =====================================================
  // nrzi coder
  // =====================================================
  // encode on transmit clock rising edge: zero toggles, one holds
  // own edge detect, so the timer 3 source choice cannot stall it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_level_r      <= 1'b1;
      nrzi_txc_prev_r <= 1'b0;
    end else begin
      nrzi_txc_prev_r <= porta_transmit_clock;
      if (porta_transmit_clock && !nrzi_txc_prev_r) begin
        tx_level_r <= porta_txd ? tx_level_r : ~tx_level_r;
      end
    end
  end

  // decode: a change of level is a zero, no change a one
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_prev_r       <= 1'b1;
      rx_decoded_r    <= 1'b1;
      rx_clock_prev_r <= 1'b0;
    end else begin
      rx_clock_prev_r <= porta_receive_clock;
      if (porta_receive_clock && !rx_clock_prev_r) begin
        rx_prev_r    <= line_rxd;
        rx_decoded_r <= ~(line_rxd ^ rx_prev_r);
      end
    end
  end

  // bypass when nrzi is off
  assign line_txd  = nrzi_select_n ? porta_txd : tx_level_r;
  assign porta_rxd = nrzi_select_n ? line_rxd  : rx_decoded_r;

  // =====================================================
  // receive bytes into fifo for bit tracking
  // =====================================================
  // assembles port a receive bits; overrun flags a dropped byte
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_r      <= 8'h00;
      shift_cnt_r  <= 3'h0;
      shift_push_r <= 1'b0;
      rx_overrun   <= 1'b0;
    end else begin
      shift_push_r <= 1'b0;
      if (porta_receive_clock && !rx_clock_prev_r) begin
        shift_r     <= {porta_rxd, shift_r[7:1]};
        shift_cnt_r <= shift_cnt_r + 3'h1;
        if (shift_cnt_r == 3'h7) begin
          shift_push_r <= 1'b1;
          if (!fifo_in_ready) rx_overrun <= 1'b1;  // sticky, until reset
        end
      end
    end
  end

  sync_fifo #(
    .WIDTH (serial_glue_pkg::FIFO_WIDTH),
    .DEPTH (serial_glue_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (shift_push_r),
    .in_ready  (fifo_in_ready),
    .in_data   (shift_r),
    .out_valid (rx_word_valid),
    .out_ready (rx_word_ready),
    .out_data  (rx_word)
  );

  // =====================================================
  // interrupt daisy chain
  // =====================================================
  // top of chain always enabled; each source passes enable down
  // only when neither requesting nor in service
  always_comb begin
    chain_en[0] = 1'b1;
    for (int i = 0; i < serial_glue_pkg::IRQ_SOURCES; i++) begin
      // sources 0-3 timer, 4-5 serial ctrl, 6-7 uart
      chain_en[i+1] = chain_en[i] & ~irq_src.req[i] & ~in_service[i];
    end
  end
  assign chain_enable_out = chain_en[serial_glue_pkg::IRQ_SOURCES];

  // lowest index wins
  always_comb begin
    winner_idx = 3'h0;
    any_req    = 1'b0;
    for (int i = serial_glue_pkg::IRQ_SOURCES - 1; i >= 0; i--) begin
      if (irq_src.req[i] && chain_en[i]) begin
        winner_idx = 3'(i);
        any_req    = 1'b1;
      end
    end
  end

  // shared active-low request
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~(|irq_src.req);
    end
  end

  // =====================================================
  // acknowledge sequencer
  // =====================================================
  always_comb begin
    ack_nxt = ack_r;
    case (ack_r)
      ACK_IDLE:  if (!opcode_fetch_strobe_n && io_request_strobe_n) ack_nxt = ACK_FETCH;
      ACK_FETCH: begin
        if (opcode_fetch_strobe_n) ack_nxt = ACK_IDLE;  // plain fetch, no ack
        else if (!io_request_strobe_n) ack_nxt = ACK_DRIVE;
      end
      ACK_DRIVE: if (opcode_fetch_strobe_n || io_request_strobe_n) ack_nxt = ACK_IDLE;
      default:   ack_nxt = ACK_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_r <= ACK_IDLE;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  // vector captured at ack entry; only the winning source drives
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vector_r       <= serial_glue_pkg::VECTOR_RESET;
      vector_drive_r <= 1'b0;
    end else begin
      vector_drive_r <= (ack_nxt == ACK_DRIVE) && any_req;
      if (ack_r == ACK_FETCH && ack_nxt == ACK_DRIVE) begin
        vector_r <= irq_src.vector[winner_idx];
      end
    end
  end
  assign vector_data  = vector_r;
  assign vector_drive = vector_drive_r;

endmodule : serial_glue
`default_nettype wire

// [verification/serial_glue_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// port checks of the clock and interrupt glue
// ==========
module serial_glue_checker (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // interrupt chain
  input wire serial_glue_pkg::irq_bundle_s irq_src,
  input wire logic [7:0] in_service,
  input wire logic       opcode_fetch_strobe_n,
  input wire logic       io_request_strobe_n,
  input wire logic       irq_n,
  input wire logic       chain_enable_out,
  input wire logic       vector_drive,
  // clock routing
  input wire logic [2:0] timer_out,
  input wire logic       clock_source_select_n,
  input wire logic       ext_receive_clock,
  input wire logic       ext_transmit_clock,
  input wire logic       porta_receive_clock,
  input wire logic       porta_transmit_clock,
  input wire logic       uart_a_clock,
  input wire logic       timer_clock_tick,
  input wire logic       timer3_clock_tick,
  input wire logic [7:0] bit_count,
  input wire logic       network_link_clock,
  // sideband
  input wire logic       reset_switch_sense,
  input wire logic       vsync_strobe_n,
  input wire logic       keyboard_dtr_n,
  input wire logic       network_carrier_detect_n,
  input wire logic       keyboard_ring_indicator_n,
  input wire logic       keyboard_ready_n
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // shared line follows any request one cycle late
  property p_irq; 1 |=> irq_n == ($past(irq_src.req) == 8'h00); endproperty
  a_irq: assert property (p_irq) else $error("irq line wrong");
  // chain passes on only when nobody requests or is served
  property p_chain; chain_enable_out == ((irq_src.req | in_service) == 8'h00); endproperty
  a_chain: assert property (p_chain) else $error("chain enable wrong");
  // a vector only answers a fetch plus io strobe
  property p_drive_ack; vector_drive |-> $past(!opcode_fetch_strobe_n) && $past(!io_request_strobe_n); endproperty
  a_drive_ack: assert property (p_drive_ack) else $error("vector without acknowledge");
  // no vector when nothing requested
  property p_drive_req; vector_drive |-> $past(irq_src.req) != 8'h00; endproperty
  a_drive_req: assert property (p_drive_req) else $error("vector without request");
  // timer input tick every second clock
  property p_tick; timer_clock_tick |=> !timer_clock_tick ##1 timer_clock_tick; endproperty
  a_tick: assert property (p_tick) else $error("timer tick spacing wrong");
  // network clock: high two, low three
  property p_net; $rose(network_link_clock) |=> network_link_clock ##1 !network_link_clock [*3] ##1 network_link_clock; endproperty
  a_net: assert property (p_net) else $error("network clock shape wrong");
  // bit counter moves exactly with the timer 3 tick
  property p_count; 1 |=> bit_count == $past(bit_count) + {7'h0, $past(timer3_clock_tick)}; endproperty
  a_count: assert property (p_count) else $error("bit count wrong");
  // port a clocks: on-board timers or off-board pins
  property p_mux; porta_receive_clock == (clock_source_select_n ? ext_receive_clock : timer_out[1])
    && porta_transmit_clock == (clock_source_select_n ? ext_transmit_clock : timer_out[0]); endproperty
  a_mux: assert property (p_mux) else $error("port a clock select wrong");
  // uart port a runs from timer 2
  property p_uart; uart_a_clock == timer_out[2]; endproperty
  a_uart: assert property (p_uart) else $error("uart clock wrong");
  // sideband lines are one flop behind their sources
  property p_side; 1 |=> {network_carrier_detect_n, keyboard_ring_indicator_n, keyboard_ready_n}
    == {!$past(reset_switch_sense), $past(vsync_strobe_n), $past(keyboard_dtr_n)}; endproperty
  a_side: assert property (p_side) else $error("sideband wrong");
endmodule : serial_glue_checker

bind serial_glue serial_glue_checker u_chk (.*);
`default_nettype wire

// [verification/serial_line_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// far side: cpu board tick and off-board serial line
// ==========
module serial_line_model #(
  parameter int unsigned KBD_GAP = 3  // clocks between reference ticks
) (
  // clock
  input  wire logic       clock,
  // frame request
  input  wire logic       send,
  input  wire logic [7:0] send_byte,
  output logic            busy,
  // line side
  output logic            ext_receive_clock,
  output logic            line_rxd,
  // reference tick
  output logic            kbd_ref_tick
);
  int unsigned gap_r = 0;  // place in the tick gap

  initial begin
    busy = 1'b0;
    ext_receive_clock = 1'b0;  // stands still outside frames
    line_rxd = 1'b0;
  end

  // ==========
  // reference tick, one clock wide
  // ==========
  always @(negedge clock) begin
    gap_r <= (gap_r == KBD_GAP - 1) ? 0 : gap_r + 1;
  end
  assign kbd_ref_tick = (gap_r == KBD_GAP - 1);

  // ==========
  // frame: lsb first, data held two clocks each side of the rise
  // ==========
  always begin
    @(negedge clock iff send);
    busy = 1'b1;
    for (int b = 0; b < 8; b++) begin
      line_rxd = send_byte[b];
      repeat (2) @(negedge clock);
      ext_receive_clock = 1'b1;
      repeat (2) @(negedge clock);
      ext_receive_clock = 1'b0;
    end
    @(negedge clock);
    line_rxd = ~line_rxd;  // released line must not look like a held bit
    busy = 1'b0;
  end
endmodule : serial_line_model
`default_nettype wire

// [verification/serial_glue_tb.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// self-checking bench of the serial board glue
// ==========
module serial_glue_tb;
  localparam int unsigned KBD_GAP = 3;  // short gap keeps the run brief
  // stimulus, all valued at time zero
  logic clock = 1'b0, rst_n = 1'b0, timer3_from_tx_clock = 1'b0, nrzi_select_n = 1'b1;
  logic clock_source_select_n = 1'b1, reset_switch_sense = 1'b0, vsync_strobe_n = 1'b1;
  logic keyboard_dtr_n = 1'b1, opcode_fetch_strobe_n = 1'b1, io_request_strobe_n = 1'b1;
  logic ext_transmit_clock = 1'b0, porta_txd = 1'b1, rx_word_ready = 1'b0, send = 1'b0;
  logic [2:0] timer_out = 3'h0;
  logic [7:0] in_service = 8'h00, send_byte = 8'h00;
  serial_glue_pkg::irq_bundle_s irq_src = 72'h0;
  // from the line model and the design
  logic kbd_ref_tick, ext_receive_clock, line_rxd, busy, irq_n, chain_enable_out, vector_drive;
  logic timer_clock_tick, timer3_clock_tick, porta_receive_clock, porta_transmit_clock, line_txd;
  logic porta_rxd, uart_a_clock, network_link_clock, network_carrier_detect_n, rx_overrun;
  logic keyboard_shared_serial_clock, keyboard_ring_indicator_n, keyboard_ready_n, rx_word_valid;
  logic [7:0] vector_data, bit_count, rx_word, vec, obs, base;
  logic drv;
  int failures = 0, checks_done = 0, n;
  wire logic [2:0] watched = {keyboard_shared_serial_clock, network_link_clock, timer_clock_tick};

  always #5 clock = ~clock;

  serial_glue dut (.*);

  serial_line_model #(.KBD_GAP(KBD_GAP)) u_line (.*);

  // ==========
  // helpers
  // ==========
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic idle(input int c);
    repeat (c) @(negedge clock);
  endtask : idle

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // acknowledge cycle; entered at a falling edge, fetch may be left out
  task automatic ack(input logic fetch, output logic got, output logic [7:0] v);
    got = 1'b0;
    v = 8'h00;
    opcode_fetch_strobe_n = ~fetch;
    idle(2);
    io_request_strobe_n = 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      #1;
      if (vector_drive === 1'b1 && !got) begin
        got = 1'b1;
        v = vector_data;
      end
    end
    @(negedge clock);
    opcode_fetch_strobe_n = 1'b1;
    io_request_strobe_n = 1'b1;
    idle(2);
  endtask : ack

  // one byte over the off-board line, waits for the model
  task automatic push(input logic [7:0] b);
    send_byte = b;
    send <= 1'b1;
    @(negedge clock);
    send <= 1'b0;
    idle(2);
    for (n = 0; n < 200 && busy; n++) @(negedge clock);
  endtask : push

  // clocks from one rise to the next; a hang is left to the watchdog
  task automatic period(input int w, output int c);
    logic p;
    int r;
    r = 0;
    c = 0;
    p = watched[w];
    while (r < 2) begin
      @(posedge clock);
      #1;
      r += int'(watched[w] && !p);
      c += int'(r == 1);
      p = watched[w];
    end
  endtask : period

  // ==========
  // main sequence
  // ==========
  initial begin
    idle(11);
    obs = {irq_n, vector_drive, network_carrier_detect_n, keyboard_ring_indicator_n, keyboard_ready_n,
           rx_word_valid, rx_overrun, 1'b0};
    check("reset outputs", 8'hb8, obs);
    check("reset count", 8'h00, bit_count);
    @(negedge clock);
    rst_n = 1'b1;
    $display("test reset finished");
    // each source with every lower one also asking
    for (int k = 0; k < 8; k++) irq_src.vector[k] = 8'h40 + 8'(k * 4);
    for (int i = 0; i < 8; i++) begin
      irq_src.req = 8'hff << i;
      idle(2);
      check("irq and chain", 8'h00, {6'h0, irq_n, chain_enable_out});
      ack(1'b1, drv, vec);
      check("vector", 8'h40 + 8'(i * 4), drv ? vec : 8'hxx);
    end
    // source 0 in service blocks all lower requests
    in_service = 8'h01;
    irq_src.req = 8'hfe;
    idle(2);
    ack(1'b1, drv, vec);
    check("blocked", 8'h00, {7'h0, drv});
    in_service = 8'h00;
    irq_src.req = 8'h10;
    ack(1'b0, drv, vec);
    check("io alone", 8'h00, {7'h0, drv});
    irq_src.req = 8'h00;
    idle(2);
    check("idle chain", 8'h03, {6'h0, irq_n, chain_enable_out});
    $display("test chain finished");
    // every select, transmit pin and timer combination; receive pin held low by the model
    for (int k = 0; k < 32; k++) begin
      {clock_source_select_n, ext_transmit_clock, timer_out} = 5'(k);
      #1;
      vec = {5'h0, clock_source_select_n ? ext_receive_clock : timer_out[1],
             clock_source_select_n ? ext_transmit_clock : timer_out[0], timer_out[2]};
      check("clock routing", vec, {5'h0, porta_receive_clock, porta_transmit_clock, uart_a_clock});
      @(negedge clock);
    end
    {clock_source_select_n, ext_transmit_clock, timer_out} = 5'h10;
    idle(2);
    // timer 3 counts only its chosen source
    base = bit_count;
    for (int s = 0; s < 2; s++) begin
      timer3_from_tx_clock = s[0];
      for (int k = 0; k < 4; k++) begin
        timer_out[0] = (s == 0) || (k < 1);
        ext_transmit_clock = (s == 1) || (k < 2);
        idle(2);
        {timer_out[0], ext_transmit_clock} = 2'h0;
        idle(2);
      end
    end
    check("bit count", base + 8'h08, bit_count);
    {nrzi_select_n, porta_txd} = 2'h0;
    idle(1);
    base = {7'h0, line_txd};
    ext_transmit_clock = 1'b1;
    idle(2);
    check("nrzi zero", base ^ 8'h01, {7'h0, line_txd});
    {nrzi_select_n, porta_txd, ext_transmit_clock} = 3'h6;
    $display("test routing finished");
    for (int w = 0; w < 3; w++) begin
      period(w, n);
      check("period", 8'(w == 0 ? 2 : w == 1 ? 5 : 20 * KBD_GAP), 8'(n));
    end
    for (int k = 0; k < 8; k++) begin
      {reset_switch_sense, vsync_strobe_n, keyboard_dtr_n} = 3'(k);
      idle(2);
      vec = {5'h0, ~reset_switch_sense, vsync_strobe_n, keyboard_dtr_n};
      obs = {5'h0, network_carrier_detect_n, keyboard_ring_indicator_n, keyboard_ready_n};
      check("sideband", vec, obs);
    end
    $display("test dividers finished");
    // routing test left receive bits behind: reset aligns the shifter
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    // fill past the top with the reader stalled, then drain
    for (int i = 0; i < 17; i++) push(8'h3c ^ 8'(i * 7));
    idle(4);
    check("overrun", 8'h03, {6'h0, rx_word_valid, rx_overrun});
    for (int i = 0; i < 16; i++) begin
      check("rx word", 8'h3c ^ 8'(i * 7), rx_word_valid ? rx_word : 8'hxx);
      rx_word_ready = 1'b1;
      idle(1);
      rx_word_ready = 1'b0;
      idle(1);
    end
    check("drained", 8'h00, {7'h0, rx_word_valid});
    $display("test buffer finished");
    end_of_test();
  end

  // hang guard, well past the thousand or so clocks needed
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    end_of_test();
  end
endmodule : serial_glue_tb
`default_nettype wire
